// ### rtl/uoc_otp_config.sv
// One-time-programmable USB descriptor and FIFO purge configuration store.
// Functional notes
// RL1 - Vendor identifier is low byte at 0x012 and high byte at 0x013.
// RL2 - Product identifier is low byte at 0x014 and high byte at 0x015.
// RL3 - Power byte is reported as bMaxPower; valid codes 0x01 to 0xFA.
// RL4 - Wake valid bit 2 set copies wake enable into bmAttributes D5.
// RL5 - Wake enable bit 3: zero disables, one enables remote wakeup.
// RL6 - Mode bits 1:0: 00 bus powered, 01/10 self powered, 11 invalid.
// RL7 - Purge bits 4 and 3 empty receive FIFO on close and open.
// RL8 - Purge bits 2 and 1 empty transmit FIFO on close and open.
// RL9 - Stored field value is used only while its burn flag is one.
// RL10 - A field whose burn flag is set refuses further programming.
// RL11 - Programmer loads whole field before its flag; unloaded parts burn zero.
// RL12 - Flag byte a: bit7 language, 4/3 port pins, 2 serial, 1/0 product.
// RL13 - Flag byte b: maker text 2/1, flush, release, attributes, power, ids.
// RL14 - Programmer sets burn flags itself; the device never sets them.
// RL15 - Programmer writes zero to every reserved bit.
// RL16 - Port open and close come from control requests; one purge per event.
`default_nettype none
module uoc_otp_config
  import uoc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire uoc_pkg::uoc_req_s req,
  input wire logic port_ctrl_valid,
  input wire logic port_ctrl_open,
  output logic [7:0] rdata,
  output logic rd_ack,
  output logic wr_refused,
  output uoc_pkg::uoc_desc_s desc,
  output logic power_code_valid,
  output logic power_mode_invalid,
  output logic rx_flush,
  output logic tx_flush,
  output logic language_code_flag,
  output logic port1_pin_setup_flag,
  output logic port0_pin_setup_flag,
  output logic serial_text_flag,
  output logic product_text_part2_flag,
  output logic product_text_part1_flag,
  output logic maker_text_part2_flag,
  output logic maker_text_part1_flag
);

  // ==========================================================================
  // Address decoding helpers.

  // Index of the burn flag in burn_flags_b that guards a data byte.
  function automatic logic [2:0] guard_bit(input logic [7:0] a);
    logic [2:0] g;
    g = 3'h0;
    case (a)
      OFS_VENDOR_ID_LOW, OFS_VENDOR_ID_HIGH: g = 3'(FLG_VENDOR_IDENTIFIER);
      OFS_PRODUCT_ID_LOW, OFS_PRODUCT_ID_HIGH: g = 3'(FLG_PRODUCT_IDENTIFIER);
      OFS_BUS_CURRENT_LIMIT: g = 3'(FLG_POWER_LIMIT);
      OFS_CONFIG_DESCRIPTOR_FLAGS: g = 3'(FLG_ATTRIBUTES);
      OFS_VERSION_HIGH, OFS_VERSION_LOW: g = 3'(FLG_RELEASE);
      OFS_FIFO_PURGE_CONTROL: g = 3'(FLG_FLUSH);
      default: g = 3'h0;
    endcase
    return g;
  endfunction

  // True when the address falls on one of the nine data bytes.
  function automatic logic is_data(input logic [7:0] a);
    return (a >= OFS_VENDOR_ID_LOW) && (a <= OFS_FIFO_PURGE_CONTROL);
  endfunction

  // Writable bits of a data byte; reserved bits are kept at zero.
  function automatic logic [7:0] data_mask(input logic [7:0] a);
    logic [7:0] m;
    m = 8'hFF;
    if (a == OFS_CONFIG_DESCRIPTOR_FLAGS) begin
      m = MASK_ATTRIBUTES;
    end else if (a == OFS_FIFO_PURGE_CONTROL) begin
      m = MASK_PURGE;
    end
    return m;
  endfunction

  // ==========================================================================
  // Storage.
  logic [7:0] otp_r [NUM_DATA];
  logic [7:0] burn_flags_a_r;
  logic [7:0] burn_flags_b_r;
  uoc_port_e port_state_r;
  uoc_port_e port_state_nxt;

  // Decoded request terms.
  wire logic [7:0] wr_idx = req.addr - OFS_VENDOR_ID_LOW;
  wire logic wr_data_sel = req.wr && is_data(req.addr);
  wire logic wr_locked = burn_flags_b_r[guard_bit(req.addr)];
  wire logic wr_data_ok = wr_data_sel && !wr_locked; // [RL10]
  wire logic wr_flag_a = req.wr && (req.addr == OFS_BURN_FLAGS_A);
  wire logic wr_flag_b = req.wr && (req.addr == OFS_BURN_FLAGS_B);

  // Each data byte stores the masked write while its field is unburned.
  // A burned field holds its value for good.
  generate
    for (genvar i = 0; i < NUM_DATA; i++) begin : g_byte
      wire logic hit = wr_data_ok && (wr_idx == 8'(i));
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          otp_r[i] <= BYTE_ZERO;
        end else if (hit) begin
          otp_r[i] <= req.wdata & data_mask(req.addr); // [RL10]
        end
      end
    end
  endgenerate

  // Burn flags only ever gain ones and only from a write; a flag once set
  // cannot be cleared, so its field stays frozen.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      burn_flags_a_r <= BYTE_ZERO;
      burn_flags_b_r <= BYTE_ZERO;
    end else begin
      if (wr_flag_a) begin
        burn_flags_a_r <= burn_flags_a_r | (req.wdata & MASK_BURN_FLAGS_A);
      end
      if (wr_flag_b) begin
        burn_flags_b_r <= burn_flags_b_r | (req.wdata & MASK_BURN_FLAGS_B);
      end
    end
  end // [RL14]

  // ==========================================================================
  // Effective field values, raw store used only once burned.
  wire logic [15:0] raw_vendor = {otp_r[1], otp_r[0]}; // [RL1]
  wire logic [15:0] raw_product = {otp_r[3], otp_r[2]}; // [RL2]
  wire logic [15:0] raw_rel = {otp_r[6], otp_r[7]};
  wire logic [15:0] eff_vendor = burn_flags_b_r[FLG_VENDOR_IDENTIFIER] ?
    raw_vendor : DEF_VENDOR_ID; // [RL9]
  wire logic [15:0] eff_product = burn_flags_b_r[FLG_PRODUCT_IDENTIFIER] ?
    raw_product : DEF_PRODUCT_ID; // [RL9]
  wire logic [7:0] eff_pwr = burn_flags_b_r[FLG_POWER_LIMIT] ?
    otp_r[4] : DEF_POWER; // [RL9]
  wire logic [7:0] eff_attr = burn_flags_b_r[FLG_ATTRIBUTES] ?
    otp_r[5] : DEF_ATTRIBUTES; // [RL9]
  wire logic [15:0] eff_rel = burn_flags_b_r[FLG_RELEASE] ?
    raw_rel : DEF_RELEASE; // [RL9]
  wire logic [7:0] eff_purge = burn_flags_b_r[FLG_FLUSH] ?
    otp_r[8] : DEF_PURGE; // [RL9]

  // Descriptor bmAttributes: D7 always one, D6 self powered, D5 wakeup.
  wire logic [1:0] mode = eff_attr[ATTR_MODE_LSB +: 2];
  wire logic self_pwr = (mode != MODE_BUS) && (mode != MODE_INVALID); // [RL6]
  wire logic wake_adv = eff_attr[ATTR_WAKE_VALID] &&
    eff_attr[ATTR_WAKE_EN]; // [RL4] [RL5]
  logic [7:0] bma;
  always_comb begin
    bma = BYTE_ZERO;
    bma[BMA_RESERVED_ONE] = 1'b1;
    bma[BMA_SELF_POWERED] = self_pwr; // [RL6]
    bma[BMA_REMOTE_WAKE] = wake_adv; // [RL4]
  end

  wire logic pwr_ok = (eff_pwr >= POWER_MIN) &&
    (eff_pwr <= POWER_MAX); // [RL3]

  // Descriptor fields and validity flags are registered.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      desc <= '0;
      power_code_valid <= 1'b0;
      power_mode_invalid <= 1'b0;
    end else begin
      desc <= '{eff_vendor, eff_product, eff_pwr, bma, eff_rel}; // [RL3]
      power_code_valid <= pwr_ok;
      power_mode_invalid <= (mode == MODE_INVALID); // [RL6]
    end
  end

  // Flag bits of byte a and the maker text bits are mirrored to outputs.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      language_code_flag <= 1'b0;
      port1_pin_setup_flag <= 1'b0;
      port0_pin_setup_flag <= 1'b0;
      serial_text_flag <= 1'b0;
      product_text_part2_flag <= 1'b0;
      product_text_part1_flag <= 1'b0;
      maker_text_part2_flag <= 1'b0;
      maker_text_part1_flag <= 1'b0;
    end else begin
      language_code_flag <= burn_flags_a_r[FLG_LANGUAGE]; // [RL12]
      port1_pin_setup_flag <= burn_flags_a_r[FLG_PORT1_PINS]; // [RL12]
      port0_pin_setup_flag <= burn_flags_a_r[FLG_PORT0_PINS]; // [RL12]
      serial_text_flag <= burn_flags_a_r[FLG_SERIAL_TEXT]; // [RL12]
      product_text_part2_flag <= burn_flags_a_r[FLG_PRODUCT_TEXT2]; // [RL12]
      product_text_part1_flag <= burn_flags_a_r[FLG_PRODUCT_TEXT1]; // [RL12]
      maker_text_part2_flag <= burn_flags_b_r[FLG_MAKER_TEXT2]; // [RL13]
      maker_text_part1_flag <= burn_flags_b_r[FLG_MAKER_TEXT1]; // [RL13]
    end
  end

  // ==========================================================================
  // Serial port open and close tracking from the host control requests.
  // Only a change of state counts, so repeated requests do not purge again.
  wire logic ev_open = port_ctrl_valid && port_ctrl_open &&
    (port_state_r == PORT_CLOSED); // [RL16]
  wire logic ev_close = port_ctrl_valid && !port_ctrl_open &&
    (port_state_r == PORT_OPEN); // [RL16]

  // Next port state.
  always_comb begin
    case (port_state_r)
      PORT_CLOSED: port_state_nxt = ev_open ? PORT_OPEN : PORT_CLOSED;
      PORT_OPEN: port_state_nxt = ev_close ? PORT_CLOSED : PORT_OPEN;
      default: port_state_nxt = PORT_CLOSED;
    endcase
  end

  wire logic rx_purge = (ev_open && eff_purge[PURGE_RX_OPEN]) ||
    (ev_close && eff_purge[PURGE_RX_CLOSE]); // [RL7]
  wire logic tx_purge = (ev_open && eff_purge[PURGE_TX_OPEN]) ||
    (ev_close && eff_purge[PURGE_TX_CLOSE]); // [RL8]

  // Port state and single-cycle purge pulses.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_state_r <= PORT_CLOSED;
      rx_flush <= 1'b0;
      tx_flush <= 1'b0;
    end else begin
      port_state_r <= port_state_nxt;
      rx_flush <= rx_purge; // [RL7] [RL16]
      tx_flush <= tx_purge; // [RL8] [RL16]
    end
  end

  // ==========================================================================
  // Register read path: raw stored bytes and flags, zero elsewhere.
  wire logic [7:0] rd_val = is_data(req.addr) ? otp_r[wr_idx[3:0]] :
    (req.addr == OFS_BURN_FLAGS_A) ? burn_flags_a_r :
    (req.addr == OFS_BURN_FLAGS_B) ? burn_flags_b_r : BYTE_ZERO;

  // Read data, read acknowledge and refused-write pulse.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= BYTE_ZERO;
      rd_ack <= 1'b0;
      wr_refused <= 1'b0;
    end else begin
      rd_ack <= req.rd;
      wr_refused <= wr_data_sel && wr_locked; // [RL10]
      if (req.rd) begin
        rdata <= rd_val;
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/uoc_pkg.sv
// Package for the USB descriptor one-time-programmable configuration store.
`default_nettype none
package uoc_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [7:0] OFS_VENDOR_ID_LOW = 8'h12;
  localparam logic [7:0] OFS_VENDOR_ID_HIGH = 8'h13;
  localparam logic [7:0] OFS_PRODUCT_ID_LOW = 8'h14;
  localparam logic [7:0] OFS_PRODUCT_ID_HIGH = 8'h15;
  localparam logic [7:0] OFS_BUS_CURRENT_LIMIT = 8'h16;
  localparam logic [7:0] OFS_CONFIG_DESCRIPTOR_FLAGS = 8'h17;
  localparam logic [7:0] OFS_VERSION_HIGH = 8'h18;
  localparam logic [7:0] OFS_VERSION_LOW = 8'h19;
  localparam logic [7:0] OFS_FIFO_PURGE_CONTROL = 8'h1A;
  localparam logic [7:0] OFS_BURN_FLAGS_A = 8'h1D;
  localparam logic [7:0] OFS_BURN_FLAGS_B = 8'h1E;

  // Number of data bytes from the low vendor byte to the purge control byte.
  localparam int NUM_DATA = 9;

  // ==========================================================================
  // Bit positions in burn_flags_b.
  localparam int FLG_VENDOR_IDENTIFIER = 0;
  localparam int FLG_PRODUCT_IDENTIFIER = 1;
  localparam int FLG_POWER_LIMIT = 2;
  localparam int FLG_ATTRIBUTES = 3;
  localparam int FLG_RELEASE = 4;
  localparam int FLG_FLUSH = 5;
  localparam int FLG_MAKER_TEXT1 = 6;
  localparam int FLG_MAKER_TEXT2 = 7;
  // Bit positions in burn_flags_a.
  localparam int FLG_PRODUCT_TEXT1 = 0;
  localparam int FLG_PRODUCT_TEXT2 = 1;
  localparam int FLG_SERIAL_TEXT = 2;
  localparam int FLG_PORT0_PINS = 3;
  localparam int FLG_PORT1_PINS = 4;
  localparam int FLG_LANGUAGE = 7;
  // Writable bits of the two flag bytes (bits 6 and 5 of byte a reserved).
  localparam logic [7:0] MASK_BURN_FLAGS_A = 8'h9F;
  localparam logic [7:0] MASK_BURN_FLAGS_B = 8'hFF;

  // ==========================================================================
  // Field layouts of the attributes and purge control bytes.
  localparam logic [7:0] MASK_ATTRIBUTES = 8'h0F;
  localparam logic [7:0] MASK_PURGE = 8'h1E;
  localparam int ATTR_WAKE_VALID = 2;
  localparam int ATTR_WAKE_EN = 3;
  localparam int ATTR_MODE_LSB = 0;
  localparam int PURGE_TX_OPEN = 1;
  localparam int PURGE_TX_CLOSE = 2;
  localparam int PURGE_RX_OPEN = 3;
  localparam int PURGE_RX_CLOSE = 4;
  localparam logic [1:0] MODE_BUS = 2'h0;
  localparam logic [1:0] MODE_INVALID = 2'h3;
  // Descriptor bmAttributes bit positions.
  localparam int BMA_RESERVED_ONE = 7;
  localparam int BMA_SELF_POWERED = 6;
  localparam int BMA_REMOTE_WAKE = 5;
  localparam logic [7:0] POWER_MIN = 8'h01;
  localparam logic [7:0] POWER_MAX = 8'hFA;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Values used while a field is not yet burned (arbitrary neutral values).
  localparam logic [15:0] DEF_VENDOR_ID = 16'h0000;
  localparam logic [15:0] DEF_PRODUCT_ID = 16'h0000;
  localparam logic [7:0] DEF_POWER = 8'h32;
  localparam logic [7:0] DEF_ATTRIBUTES = 8'h00;
  localparam logic [15:0] DEF_RELEASE = 16'h0100;
  localparam logic [7:0] DEF_PURGE = 8'h00;

  // ==========================================================================
  // Types.
  typedef enum logic {PORT_CLOSED, PORT_OPEN} uoc_port_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } uoc_req_s;

  typedef struct packed {
    logic [15:0] vendor_id;
    logic [15:0] product_id;
    logic [7:0] max_power;
    logic [7:0] bm_attributes;
    logic [15:0] release_bcd;
  } uoc_desc_s;

endpackage
`default_nettype wire

// ### test/tb_usb_descriptor_otp_config.sv
// Self-checking bench for the configuration store with a reference model.
`default_nettype none
module tb_usb_descriptor_otp_config;
  timeunit 1ns;
  timeprecision 1ns;
  import uoc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  uoc_req_s req;
  uoc_desc_s desc;
  logic [7:0] rdata;
  logic port_ctrl_valid, port_ctrl_open, rd_ack, wr_refused;
  logic pcv, pmi, rxf, txf;
  wire [7:0] fa;
  wire [1:0] fm;
  // The two reserved flag positions have no output; they read as zero.
  assign fa[6:5] = 2'b00;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_0038;
  logic [7:0] m [0:31];
  logic open_m;
  int gb [18:26] = '{0, 0, 1, 1, 2, 3, 4, 4, 5};
  logic [7:0] pwt [4] = '{8'h00, 8'h01, 8'hFA, 8'hFB};
  always #25 clk = ~clk;
  uoc_otp_config dut_u (.clk, .nrst, .req, .port_ctrl_valid, .port_ctrl_open,
    .rdata, .rd_ack, .wr_refused, .desc, .power_code_valid(pcv),
    .power_mode_invalid(pmi), .rx_flush(rxf), .tx_flush(txf),
    .language_code_flag(fa[7]), .port1_pin_setup_flag(fa[4]),
    .port0_pin_setup_flag(fa[3]), .serial_text_flag(fa[2]),
    .product_text_part2_flag(fa[1]), .product_text_part1_flag(fa[0]),
    .maker_text_part2_flag(fm[1]), .maker_text_part1_flag(fm[0]));
  uoc_host_model u_host (.clk, .req, .port_ctrl_valid, .port_ctrl_open);
  // ==========================================================================
  // Reference model, comparison and run control.
  function automatic logic [7:0] nx();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Model write: returns one when the guarded field is already burned.
  function automatic logic mwr(input logic [7:0] a, d);
    if (a >= 8'h12 && a <= 8'h1A && m[30][gb[a]]) return 1'b1;
    case (a)
      8'h17: m[a] = d & 8'h0F;
      8'h1A: m[a] = d & 8'h1E;
      8'h1D: m[a] |= d & 8'h9F;
      8'h1E: m[a] |= d;
      default: if (a >= 8'h12 && a <= 8'h19) m[a] = d;
    endcase
    return 1'b0;
  endfunction
  function automatic uoc_desc_s mdesc();
    logic [7:0] at;
    at = m[30][3] ? m[23] : DEF_ATTRIBUTES;
    mdesc.vendor_id = m[30][0] ? {m[19], m[18]} : DEF_VENDOR_ID;
    mdesc.product_id = m[30][1] ? {m[21], m[20]} : DEF_PRODUCT_ID;
    mdesc.max_power = m[30][2] ? m[22] : DEF_POWER;
    mdesc.release_bcd = m[30][4] ? {m[24], m[25]} : DEF_RELEASE;
    mdesc.bm_attributes = {1'b1, at[1] ^ at[0], at[2] & at[3], 5'h00};
  endfunction
  task automatic chk(input logic [63:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic e;
    e = mwr(a, d);
    u_host.xfer(1'b1, 1'b0, a, d);
    #1 chk(wr_refused, e, "refusal");
  endtask
  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, 1'b1, a, 8'h00);
    #1 chk(rd_ack, 1'b1, "read answer");
    chk(rdata, (a == 27 || a == 28) ? 8'h00 : m[a],
      "read data");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      $display("[ERR] %0t cycle limit reached", $time);
      tally_and_finish();
    end
  end
  // Each pass: reset, load data bytes, then flags, then read and exercise.
  initial begin
    logic [7:0] d, p;
    logic o, ev;
    for (int i = 0; i < 16; i++) begin
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      foreach (m[k]) m[k] = 8'h00;
      open_m = 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(desc, mdesc(), "defaults");
      chk({fm, fa & 8'h9F}, 10'h000, "flags after reset");
      for (int a = 18; a <= 26; a++) begin
        d = (a == 22) ? pwt[i % 4] : (a == 23) ? i[7:0] : nx();
        wr(a[7:0], (a == 26) ? d & 8'h1E : d);
      end
      wr(8'h1D, nx() & 8'h9F);
      wr(8'h1E, nx() | 8'h0C);
      wr(8'h12 + 8'(nx() % 5), nx());
      wr(8'h1E, 8'h00);
      for (int a = 18; a <= 30; a++) rd(a[7:0]);
      @(posedge clk);
      #1 chk(desc, mdesc(), "descriptor");
      chk(pcv, m[22] inside {[8'h01:8'hFA]}, "power code");
      chk(pmi, m[23][1:0] == 2'b11, "mode invalid");
      chk({fm, fa & 8'h9F}, {m[30][7:6], m[29]}, "flags");
      p = m[30][5] ? m[26] : DEF_PURGE;
      for (int j = 0; j < 6; j++) begin
        o = nx() > 8'h7F;
        ev = (o != open_m);
        u_host.port_req(o);
        #1 chk(txf, ev & (o ? p[1] : p[2]), "tx purge");
        chk(rxf, ev & (o ? p[3] : p[4]), "rx purge");
        if (ev) open_m = o;
      end
      $display("test %0d done", i);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### test/uoc_host_model.sv
// Host model issuing register and serial-port control requests.
`default_nettype none
module uoc_host_model (
  input wire logic clk,
  output var uoc_pkg::uoc_req_s req,
  output logic port_ctrl_valid,
  output logic port_ctrl_open
);
  timeunit 1ns;
  timeprecision 1ns;
  import uoc_pkg::*;
  // ==========================================================================
  // Idle until the bench asks; released lines show inverted junk.
  initial begin
    req = '0;
    port_ctrl_valid = 1'b0;
    port_ctrl_open = 1'b0;
  end
  // One register transfer held for exactly one edge.
  task automatic xfer(input logic w, r, input logic [7:0] a, d);
    @(posedge clk);
    req <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // One serial-port control request decoded as open or close.
  task automatic port_req(input logic o);
    @(posedge clk);
    port_ctrl_valid <= 1'b1;
    port_ctrl_open <= o;
    @(posedge clk);
    port_ctrl_valid <= 1'b0;
    port_ctrl_open <= ~o;
  endtask
endmodule
`default_nettype wire

// ### test/uoc_otp_config_props.sv
// Concurrent checks on the ports of the configuration store.
`default_nettype none
module uoc_otp_config_props (
  input wire logic clk,
  input wire logic nrst,
  input wire uoc_pkg::uoc_req_s req,
  input wire logic port_ctrl_valid,
  input wire logic port_ctrl_open,
  input wire logic [7:0] rdata,
  input wire logic rd_ack,
  input wire logic wr_refused,
  input wire uoc_pkg::uoc_desc_s desc,
  input wire logic power_code_valid,
  input wire logic power_mode_invalid,
  input wire logic rx_flush,
  input wire logic tx_flush,
  input wire logic language_code_flag,
  input wire logic maker_text_part1_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  import uoc_pkg::*;
  // ==========================================================================
  // Helper: port state, so a repeated open or close is not an event.
  logic open_r;
  wire evt = port_ctrl_valid && (port_ctrl_open != open_r);
  wire flag_wr = req.wr && (req.addr == OFS_BURN_FLAGS_A);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      open_r <= 1'b0;
    end else if (evt) begin
      open_r <= port_ctrl_open;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // Assertions.
  chk_ack_follows: assert property (req.rd |=> rd_ack)
    else $error("read not answered next cycle");
  chk_ack_only_rd: assert property (rd_ack |-> $past(req.rd))
    else $error("answer without a read");
  chk_rdata_hold: assert property (!$past(req.rd) |-> $stable(rdata))
    else $error("read data moved without a read");
  chk_refuse_data: assert property (wr_refused |-> $past(req.wr) &&
    $past(req.addr) inside {[OFS_VENDOR_ID_LOW:OFS_FIFO_PURGE_CONTROL]})
    else $error("refusal without a data write");
  chk_power_code: assert property (power_code_valid ==
    (desc.max_power inside {[POWER_MIN:POWER_MAX]}))
    else $error("power code range flag wrong");
  chk_mode_bus: assert property (power_mode_invalid |->
    !desc.bm_attributes[BMA_SELF_POWERED])
    else $error("invalid mode reported self powered");
  chk_top_bit: assert property ($past(nrst) |->
    desc.bm_attributes[BMA_RESERVED_ONE])
    else $error("attributes top bit clear");
  chk_rx_cause: assert property (rx_flush |-> $past(evt))
    else $error("receive purge without a port event");
  chk_tx_cause: assert property (tx_flush |-> $past(evt))
    else $error("transmit purge without a port event");
  chk_flag_rise: assert property ($rose(language_code_flag) |->
    $past(flag_wr) || $past(flag_wr, 2))
    else $error("flag set without a flag write");
  chk_flag_keep: assert property (!$fell(maker_text_part1_flag))
    else $error("burn flag cleared");
endmodule
bind uoc_otp_config uoc_otp_config_props chk_u (.clk, .nrst, .req,
  .port_ctrl_valid, .port_ctrl_open, .rdata, .rd_ack, .wr_refused, .desc,
  .power_code_valid, .power_mode_invalid, .rx_flush, .tx_flush,
  .language_code_flag, .maker_text_part1_flag);
`default_nettype wire
